//--- src/pdcs_pkg.sv
// Constants for the device control and status register pair
package pdcs_pkg;
    // Register byte addresses
    localparam logic [11:0] PDCS_ADDR_WIDTH_DUMMY = 12'h000;
    localparam logic [11:0] PDCS_OFF_DEVCTL       = 12'h0E8;
    localparam logic [11:0] PDCS_OFF_IRQ_STAT     = 12'h200;
    localparam logic [11:0] PDCS_OFF_IRQ_MASK     = 12'h204;
    // Control half field positions
    localparam int          PDCS_CTL_EN_LSB       = 0;
    localparam int          PDCS_CTL_MPS_LSB      = 5;
    localparam int          PDCS_CTL_AUXPM_BIT    = 10;
    // Status half field positions
    localparam int          PDCS_STS_ERR_LSB      = 16;
    localparam int          PDCS_STS_AUXDET_BIT   = 20;
    // Error class count
    localparam int          PDCS_NERR             = 4;
    // Payload size codes: only 128 bytes supported
    localparam logic [2:0]  PDCS_MPS_SUPPORTED    = 3'h0;
    // Reset values
    localparam logic [3:0]  PDCS_EN_RST           = 4'h0;
    localparam logic [2:0]  PDCS_MPS_RST          = 3'h0;
    localparam logic        PDCS_AUXPM_RST        = 1'h0;
    localparam logic        PDCS_AUXDET_RST       = 1'h1;
    localparam logic [3:0]  PDCS_ERR_RST          = 4'h0;
    localparam logic [3:0]  PDCS_IRQ_MASK_RST     = 4'h0;
    localparam logic [31:0] PDCS_RDATA_RST        = 32'h0000_0000;
    // Logger sequencing
    typedef enum logic [0:0] {
        PDCS_LOG_IDLE = 1'b0,
        PDCS_LOG_SEEN = 1'b1
    } pdcs_log_e;
endpackage

//--- src/pdcs_err_if.sv
// Carrier between register front end and error logger
`timescale 1ns/1ns
interface pdcs_err_if;
    logic [3:0] det;     // Error detect pulses
    logic [3:0] en;      // Reporting enables
    logic [3:0] clr;     // Write-one-to-clear mask, one cycle
    logic [3:0] status;  // Sticky detected flags
    logic [3:0] msg;     // Upstream message pulses
    modport logger (input det, input en, input clr, output status, output msg);
    modport front  (output det, output en, output clr, input status, input msg);
endinterface

//--- src/pdcs_err_log.sv
// Error-detected flags and gated upstream error messages
`timescale 1ns/1ns
module pdcs_err_log
    import pdcs_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   resetn,
    pdcs_err_if.logger  eif
);
    typedef struct packed {
        logic [3:0] status;
        logic [3:0] msg;
        pdcs_log_e  seen;
    } pdcs_log_s;

    pdcs_log_s st_reg;
    pdcs_log_s st_next;

    // Detection always logs; message needs the enable
    always_comb begin
        st_next        = st_reg;
        // Set beats clear so a same-cycle error is never lost
        st_next.status = (st_reg.status & ~eif.clr) | eif.det;
        st_next.msg    = eif.det & eif.en;
        case (st_reg.seen)
            PDCS_LOG_IDLE: begin
                if (|eif.det) begin
                    st_next.seen = PDCS_LOG_SEEN;
                end
            end
            PDCS_LOG_SEEN: begin
                if (st_next.status == 4'h0) begin
                    st_next.seen = PDCS_LOG_IDLE;
                end
            end
            default: begin
                st_next.seen = PDCS_LOG_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '{status: PDCS_ERR_RST, msg: 4'h0, seen: PDCS_LOG_IDLE};
        end else begin
            st_reg <= st_next;
        end
    end

    assign eif.status = st_reg.status;
    assign eif.msg    = st_reg.msg;

    // Checks on logging and message gating
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_chk
        log_sets_a: assert property (eif.det[gi] |=> eif.status[gi])
            else $error("detected error not logged");
        log_holds_a: assert property (eif.status[gi] && !eif.clr[gi] |=> eif.status[gi])
            else $error("status bit dropped without a write of one");
        log_clears_a: assert property (eif.clr[gi] && !eif.det[gi] |=> !eif.status[gi])
            else $error("write of one did not clear status");
        msg_gate_a: assert property (eif.msg[gi] |-> $past(eif.det[gi]) && $past(eif.en[gi]))
            else $error("message sent without detect and enable");
        msg_sent_a: assert property (eif.det[gi] && eif.en[gi] |=> eif.msg[gi])
            else $error("enabled error sent no message");
    end
endmodule

//--- src/pdcs_top.sv
// Device control and status register pair with error logging and interrupt
`timescale 1ns/1ns
module pdcs_top
    import pdcs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        por_resetn,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [3:0]  err_detect,
    input  wire logic        aux_pwr_present,
    output logic      [3:0]  err_msg,
    output logic      [2:0]  max_payload,
    output logic             aux_pm_enable,
    output logic             irq
);
    typedef struct packed {
        logic [3:0]  en;
        logic [2:0]  mps;
        logic        aux_det;
        logic [3:0]  irq_stat;
        logic [3:0]  irq_mask;
        logic [31:0] rdata;
    } pdcs_core_s;

    typedef struct packed {
        logic aux_pm;
    } pdcs_sticky_s;

    pdcs_core_s   core_reg;
    pdcs_core_s   core_next;
    pdcs_sticky_s stk_reg;
    pdcs_sticky_s stk_next;

    pdcs_err_if eif ();

    pdcs_err_log u_log (
        .mclk   (mclk),
        .resetn (resetn),
        .eif    (eif)
    );

    logic        wr_ctl;
    logic        wr_istat;
    logic        wr_imask;
    logic [2:0]  mps_wr;
    logic [31:0] ctl_word;

    // Address decode
    assign wr_ctl   = reg_wr && (reg_addr == PDCS_OFF_DEVCTL);
    assign wr_istat = reg_wr && (reg_addr == PDCS_OFF_IRQ_STAT);
    assign wr_imask = reg_wr && (reg_addr == PDCS_OFF_IRQ_MASK);

    // Clamp: only the 128-byte code exists, so any larger code folds down
    assign mps_wr = (reg_wdata[PDCS_CTL_MPS_LSB +: 3] > PDCS_MPS_SUPPORTED)
                  ? PDCS_MPS_SUPPORTED
                  : reg_wdata[PDCS_CTL_MPS_LSB +: 3];

    // Connect logger
    assign eif.det = err_detect;
    assign eif.en  = core_reg.en;
    assign eif.clr = wr_ctl ? reg_wdata[PDCS_STS_ERR_LSB +: 4] : 4'h0;

    // Dword image; constant-zero bits are fixed here, never stored
    always_comb begin
        ctl_word                                = 32'h0000_0000;
        ctl_word[PDCS_CTL_EN_LSB +: 4]          = core_reg.en;
        ctl_word[PDCS_CTL_MPS_LSB +: 3]         = core_reg.mps;
        ctl_word[PDCS_CTL_AUXPM_BIT]            = stk_reg.aux_pm;
        ctl_word[PDCS_STS_ERR_LSB +: 4]         = eif.status;
        ctl_word[PDCS_STS_AUXDET_BIT]           = core_reg.aux_det;
    end

    // Next state for function-reset domain
    always_comb begin
        core_next = core_reg;
        if (wr_ctl) begin
            core_next.en  = reg_wdata[PDCS_CTL_EN_LSB +: 4];
            core_next.mps = mps_wr;
        end
        // Follows the power sense pin every cycle
        core_next.aux_det  = aux_pwr_present;
        // Set wins over write-one-to-clear
        core_next.irq_stat = (core_reg.irq_stat
                             & ~(wr_istat ? reg_wdata[3:0] : 4'h0)) | err_detect;
        if (wr_imask) begin
            core_next.irq_mask = reg_wdata[3:0];
        end
        // Read data stands only in the cycle after the strobe
        core_next.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                PDCS_OFF_DEVCTL:   core_next.rdata = ctl_word;
                PDCS_OFF_IRQ_STAT: core_next.rdata = {28'h0000000, core_reg.irq_stat};
                PDCS_OFF_IRQ_MASK: core_next.rdata = {28'h0000000, core_reg.irq_mask};
                default:           core_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    // Sticky enable: function reset leaves it; power-on reset or a control write of zero clears it
    always_comb begin
        stk_next = stk_reg;
        if (wr_ctl) begin
            stk_next.aux_pm = reg_wdata[PDCS_CTL_AUXPM_BIT];
        end
    end

    // Function reset domain
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            core_reg <= '{en: PDCS_EN_RST, mps: PDCS_MPS_RST, aux_det: PDCS_AUXDET_RST,
                          irq_stat: 4'h0, irq_mask: PDCS_IRQ_MASK_RST,
                          rdata: PDCS_RDATA_RST};
        end else begin
            core_reg <= core_next;
        end
    end

    // Power-on reset domain
    always_ff @(posedge mclk or negedge por_resetn) begin
        if (!por_resetn) begin
            stk_reg <= '{aux_pm: PDCS_AUXPM_RST};
        end else begin
            stk_reg <= stk_next;
        end
    end

    // Outputs
    assign reg_rdata     = core_reg.rdata;
    assign err_msg       = eif.msg;
    assign max_payload   = core_reg.mps;
    assign aux_pm_enable = stk_reg.aux_pm;
    assign irq           = |(core_reg.irq_stat & core_reg.irq_mask);

    // Checks on the register pair
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    ctl_enables_a: assert property (wr_ctl |=> core_reg.en == $past(reg_wdata[3:0]))
        else $error("reporting enables did not take the write");
    ctl_hold_a: assert property (!wr_ctl |=> $stable(core_reg.en))
        else $error("reporting enables changed without a write");
    mps_clamp_a: assert property (wr_ctl |=> max_payload == PDCS_MPS_SUPPORTED)
        else $error("payload size not clamped");
    mps_read_a: assert property (reg_rd && reg_addr == PDCS_OFF_DEVCTL
                                 |=> reg_rdata[7:5] == 3'h0)
        else $error("payload size read back nonzero");
    auxpm_wr_a: assert property (disable iff (!por_resetn)
                                 wr_ctl |=> aux_pm_enable == $past(reg_wdata[10]))
        else $error("aux power enable did not take the write");
    ro_zero_a: assert property (reg_rd && reg_addr == PDCS_OFF_DEVCTL
                                |=> (reg_rdata & 32'hFFE0_FB10) == 32'h0000_0000)
        else $error("read-only zero bits read nonzero");
    mrrs_zero_a: assert property (##1 $past(reg_rd) |-> reg_rdata[14:12] == 3'h0)
        else $error("read request size field nonzero");
    err_read_a: assert property (reg_rd && reg_addr == PDCS_OFF_DEVCTL
                                 |=> reg_rdata[19:16] == $past(eif.status))
        else $error("error status read mismatch");
    auxdet_a: assert property (aux_pwr_present ##1 reg_rd && reg_addr == PDCS_OFF_DEVCTL
                               |=> reg_rdata[20])
        else $error("aux power detected bit wrong");
    rsvd_hi_a: assert property (reg_rdata[31:22] == 10'h000)
        else $error("reserved status bits nonzero");
    bit4_15_a: assert property (reg_rdata[4] == 1'b0 && reg_rdata[15] == 1'b0)
        else $error("control bits 4 or 15 nonzero");
    rdata_pulse_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data stood outside its cycle");
    // A mask write in the same cycle may legally hide the event
    irq_raise_a: assert property (|(err_detect & core_reg.irq_mask) && !wr_imask |=> irq)
        else $error("unmasked event raised no interrupt");
    msg_needs_en_a: assert property (|err_msg |-> |$past(core_reg.en))
        else $error("message with all enables clear");

    cov_msg_c:     cover property (err_detect[2] && core_reg.en[2] ##1 err_msg[2]);
    cov_silent_c:  cover property (err_detect[0] && !core_reg.en[0] ##1 eif.status[0]);
    cov_clamp_c:   cover property (wr_ctl && reg_wdata[7:5] == 3'h5);
    cov_setclr_c:  cover property (wr_ctl && reg_wdata[16] && err_detect[0]);
endmodule

//--- sim/pdcs_host_model.sv
// Upstream host model: injects error events and counts error messages
`timescale 1ns/1ns
module pdcs_host_model (
    input  wire logic            mclk,
    input  wire logic            resetn,
    input  wire logic [3:0]      inj,
    input  wire logic [3:0]      err_msg,
    output logic      [3:0]      err_detect,
    output logic      [3:0][7:0] msg_cnt
);
    // Events leave on the edge after the bench asks, one cycle per request
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            err_detect <= 4'h0;
            msg_cnt    <= '0;
        end else begin
            err_detect <= inj;
            // One count per message pulse; no pulse means the class is gated
            for (int i = 0; i < 4; i++) begin
                if (err_msg[i] === 1'b1) msg_cnt[i] <= msg_cnt[i] + 8'h01;
            end
        end
    end
endmodule

//--- sim/pdcs_device_control_status_test.sv
// Self-checking bench for the device control and status register pair
`timescale 1ns/1ns
module pcie_device_control_status_test;
    import pdcs_pkg::*;
    logic            mclk = 1'b0;
    logic            resetn = 1'b0;
    logic            por_resetn = 1'b0;
    logic [11:0]     reg_addr = 12'h000;
    logic [31:0]     reg_wdata = 32'h0000_0000;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [31:0]     reg_rdata;
    logic [3:0]      err_detect;
    logic            aux_pwr_present = 1'b1;
    logic [3:0]      err_msg;
    logic [2:0]      max_payload;
    logic            aux_pm_enable;
    logic            irq;
    logic [3:0]      inj = 4'h0;
    logic [3:0][7:0] msg_cnt;
    logic            rd_seen = 1'b0;
    logic [31:0]     seed = 32'd47908;
    logic [31:0]     rnd;
    logic [31:0]     exp_q[$];
    int              num_errors = 0;
    int              cmp_count = 0;

    pdcs_top dut (.mclk(mclk), .resetn(resetn), .por_resetn(por_resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .err_detect(err_detect), .aux_pwr_present(aux_pwr_present),
        .err_msg(err_msg), .max_payload(max_payload), .aux_pm_enable(aux_pm_enable),
        .irq(irq));
    pdcs_host_model host (.mclk(mclk), .resetn(resetn), .inj(inj), .err_msg(err_msg),
        .err_detect(err_detect), .msg_cnt(msg_cnt));

    always #10 mclk = ~mclk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    // Expected word is queued when the read goes out
    task automatic rd(logic [11:0] a, logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(exp);
        @(posedge mclk);
        reg_rd   <= 1'b0;
    endtask

    task automatic pulse_errs(logic [3:0] v, int n);
        @(posedge mclk);
        inj <= v;
        repeat (n) @(posedge mclk);
        inj <= 4'h0;
        repeat (4) @(posedge mclk);
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    always @(posedge mclk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) check("unexpected read", 32'h1, 32'h0);
            else check("read data", reg_rdata, exp_q.pop_front());
        end
        rd_seen <= reg_rd;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge mclk);
        resetn     <= 1'b1;
        por_resetn <= 1'b1;
        rd(PDCS_OFF_DEVCTL, 32'h0010_0000);
        wr(PDCS_OFF_DEVCTL, 32'hFFFF_FFFF);
        rd(PDCS_OFF_DEVCTL, 32'h0010_040F);
        // Random control words; error status is still clear so only RW bits and the aux detect bit show
        for (int i = 0; i < 8; i++) begin
            rnd = xs();
            wr(PDCS_OFF_DEVCTL, rnd);
            rd(PDCS_OFF_DEVCTL, (rnd & 32'h0000_040F) | 32'h0010_0000);
            @(negedge mclk);
            check("payload", {29'h0, max_payload}, 32'h0);
            check("aux pm", {31'h0, aux_pm_enable}, {31'h0, rnd[10]});
        end
        // Two back-to-back events on every class with half the enables set
        wr(PDCS_OFF_DEVCTL, 32'h0000_0405);
        pulse_errs(4'hF, 2);
        check("messages", msg_cnt, 32'h0002_0002);
        rd(PDCS_OFF_DEVCTL, 32'h001F_0405);
        wr(PDCS_OFF_DEVCTL, 32'h0000_0405);
        rd(PDCS_OFF_DEVCTL, 32'h001F_0405);
        wr(PDCS_OFF_DEVCTL, 32'h0005_0405);
        rd(PDCS_OFF_DEVCTL, 32'h001A_0405);
        // Interrupt status, mask and clear
        rd(PDCS_OFF_IRQ_STAT, 32'h0000_000F);
        @(negedge mclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(PDCS_OFF_IRQ_MASK, 32'h0000_0002);
        rd(PDCS_OFF_IRQ_MASK, 32'h0000_0002);
        @(negedge mclk);
        check("irq set", {31'h0, irq}, 32'h1);
        wr(PDCS_OFF_IRQ_STAT, 32'h0000_0002);
        @(negedge mclk);
        check("irq clear", {31'h0, irq}, 32'h0);
        // Unmasked event while its reporting enable is clear still interrupts
        pulse_errs(4'h2, 1);
        check("irq event", {31'h0, irq}, 32'h1);
        wr(PDCS_OFF_IRQ_STAT, 32'h0000_0002);
        rd(PDCS_OFF_IRQ_STAT, 32'h0000_000D);
        // Unmapped place neither stores nor disturbs
        wr(12'h0EC, 32'hFFFF_FFFF);
        rd(12'h0EC, 32'h0000_0000);
        rd(PDCS_OFF_DEVCTL, 32'h001A_0405);
        // Aux power lost, then back
        aux_pwr_present <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(PDCS_OFF_DEVCTL, 32'h000A_0405);
        aux_pwr_present <= 1'b1;
        // Function reset keeps the sticky enable
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(PDCS_OFF_DEVCTL, 32'h0010_0400);
        // Power-on reset drops it; of the two resets only this one does
        // Let the pending read data be sampled before reset wipes it
        @(posedge mclk);
        por_resetn <= 1'b0;
        resetn     <= 1'b0;
        repeat (3) @(posedge mclk);
        por_resetn <= 1'b1;
        resetn     <= 1'b1;
        repeat (2) @(posedge mclk);
        check("aux pm por", {31'h0, aux_pm_enable}, 32'h0);
        rd(PDCS_OFF_DEVCTL, 32'h0010_0000);
        repeat (3) @(posedge mclk);
        check("reads left", exp_q.size(), 32'h0);
        report_and_stop();
    end
endmodule
